// ==== reset_status_power_ctrl.sv ====
// reset cause recording, stop/halt mode control and peripheral power gating
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

module reset_status_power_ctrl
  import rst_pwr_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic                             por_n,
  input  wire logic [rst_pwr_pkg::ADDR_W-1:0]   addr,
  input  wire logic [rst_pwr_pkg::DATA_W-1:0]   wdata,
  input  wire logic                             wr,
  input  wire logic                             rd,
  output logic      [rst_pwr_pkg::DATA_W-1:0]   rdata,
  input  wire logic                             ext_reset_event,
  input  wire logic                             wdt_reset_event,
  input  wire logic                             debug_reset_event,
  input  wire logic                             brownout_reset_event,
  input  wire logic                             wdt_timeout_event,
  input  wire logic                             stop_gpio_event,
  input  wire logic                             irq_pending,
  input  wire logic                             stop_instr,
  input  wire logic                             halt_instr,
  input  wire logic                             brownout_stop_option,
  output logic                                  watchdog_control_wr,
  output logic      [rst_pwr_pkg::DATA_W-1:0]   watchdog_control,
  output logic                                  cpu_clk_en,
  output logic                                  sys_clk_en,
  output logic                                  osc_en,
  output logic                                  xtal_pins_en,
  output logic                                  wdt_rc_run,
  output logic                                  wdt_logic_run,
  output logic                                  periph_clk_en,
  output logic                                  brownout_en,
  output logic                                  adc_en,
  output logic                                  comp_en
);

  // =====================================================================
  // power-on event capture
  // por_n is the raw power-on reset; rst_n covers every system reset. the
  // first clock after a power-on release reports it once to the flags.
  logic        por_seen;
  logic        por_event;

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      por_seen <= 1'b0;
    end else begin
      por_seen <= 1'b1;
    end
  end

  assign por_event = !por_seen;

  // =====================================================================
  // address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    hit = (a == base);
  endfunction

  logic        cause_read;
  logic [3:0]  flags;
  power_mode_e mode;
  power_mode_e next_mode;
  logic [7:0]  power_control_0;
  logic [7:0]  option_ctrl;
  logic        halt_exit;
  logic        stop_exit;

  assign cause_read = rd && hit(addr, RESET_CAUSE_ADDR);

  // =====================================================================
  // reset cause flags
  reset_cause_flags u_flags (
    .clk               (clk),
    .rst_n             (rst_n),
    .por_event         (por_event),
    .ext_reset_event   (ext_reset_event),
    .wdt_reset_event   (wdt_reset_event),
    .debug_reset_event (debug_reset_event),
    .wdt_timeout_event (wdt_timeout_event),
    .stop_gpio_event   (stop_gpio_event),
    .in_stop           (mode == MODE_STOP),
    .clear_read        (cause_read),
    .flags             (flags)
  );

  // =====================================================================
  // register writes
  // power control lives on the power-on reset alone so that watchdog and
  // pin resets keep the peripherals as software left them
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      power_control_0 <= PWR_RESET_VAL;
    end else if (wr && hit(addr, POWER_CONTROL_0_ADDR)) begin
      power_control_0 <= wdata;  // reserved bits stored as written
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      option_ctrl <= OPT_RESET_VAL;
    end else if (wr && hit(addr, OPTION_CTRL_ADDR)) begin
      option_ctrl <= wdata;
    end
  end

  // writes to the shared address go to watchdog control, never to the flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_control_wr <= 1'b0;
      watchdog_control    <= 8'h00;
    end else begin
      watchdog_control_wr <= wr && hit(addr, RESET_CAUSE_ADDR);
      if (wr && hit(addr, RESET_CAUSE_ADDR)) begin
        watchdog_control <= wdata;
      end
    end
  end

  // =====================================================================
  // read path, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (hit(addr, RESET_CAUSE_ADDR)) begin
        rdata <= {flags, CAUSE_RSVD_VAL};
      end else if (hit(addr, POWER_CONTROL_0_ADDR)) begin
        rdata <= power_control_0;
      end else if (hit(addr, MODE_STATUS_ADDR)) begin
        rdata <= {6'h00, mode == MODE_HALT, mode == MODE_STOP};
      end else if (hit(addr, OPTION_CTRL_ADDR)) begin
        rdata <= option_ctrl;
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // =====================================================================
  // low-power mode state
  // resets (por, brownout, pin, watchdog reset) arrive through rst_n as well;
  // the event inputs also end halt in case the reset is still being staged
  assign halt_exit = irq_pending || wdt_timeout_event || wdt_reset_event
                   || brownout_reset_event || ext_reset_event;
  assign stop_exit = stop_gpio_event || wdt_timeout_event || wdt_reset_event
                   || ext_reset_event || debug_reset_event;

  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_ACTIVE: begin
        if (stop_instr) begin
          next_mode = MODE_STOP;
        end else if (halt_instr) begin
          next_mode = MODE_HALT;
        end
      end
      MODE_HALT: begin
        if (halt_exit) begin
          next_mode = MODE_ACTIVE;
        end
      end
      MODE_STOP: begin
        if (stop_exit) begin
          next_mode = MODE_ACTIVE;
        end
      end
      default: begin
        next_mode = MODE_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_ACTIVE;
    end else begin
      mode <= next_mode;
    end
  end

  // =====================================================================
  // clock and power enables, all registered
  // enables other than wdt_logic_run follow next_mode so they switch on the same edge as the mode
  logic stop_n;
  logic run_n;

  assign stop_n = (next_mode != MODE_STOP);
  assign run_n  = (next_mode == MODE_ACTIVE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en    <= 1'b1;
      sys_clk_en    <= 1'b1;
      osc_en        <= 1'b1;
      xtal_pins_en  <= 1'b0;
      wdt_rc_run    <= 1'b1;
      wdt_logic_run <= 1'b1;
      periph_clk_en <= 1'b1;
    end else begin
      cpu_clk_en    <= run_n;
      sys_clk_en    <= stop_n;
      osc_en        <= stop_n;
      xtal_pins_en  <= stop_n && option_ctrl[OPT_XTAL_EN_BIT];
      // in halt the watchdog oscillator runs regardless; in stop only if enabled
      wdt_rc_run    <= !stop_n ? option_ctrl[OPT_WDT_RC_EN_BIT] : 1'b1;
      wdt_logic_run <= option_ctrl[OPT_WDT_EN_BIT];
      periph_clk_en <= stop_n;
    end
  end

  // peripheral gates are on por_n so a system reset cannot glitch them on
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      brownout_en <= 1'b0;
      adc_en      <= 1'b0;
      comp_en     <= 1'b0;
    end else begin
      brownout_en <= !power_control_0[PWR_BROWNOUT_BIT]
                     && (stop_n || brownout_stop_option);
      adc_en      <= !power_control_0[PWR_ADC_BIT] && stop_n;
      comp_en     <= !power_control_0[PWR_COMP_BIT] && stop_n;
    end
  end

endmodule

// ==== rst_pwr_pkg.sv ====
// package: register map, field positions, reset values and mode codes for reset/power control
package rst_pwr_pkg;

  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 8;

  // =====================================================================
  // register map
  localparam logic [11:0] POWER_CONTROL_0_ADDR = 12'hf80;
  localparam logic [11:0] RESET_CAUSE_ADDR     = 12'hff0;  // shared with watchdog_control
  localparam logic [11:0] MODE_STATUS_ADDR     = 12'hf81;
  localparam logic [11:0] OPTION_CTRL_ADDR     = 12'hf82;

  // =====================================================================
  // reset cause field positions
  localparam int          CAUSE_POR_BIT     = 7;
  localparam int          CAUSE_STOP_BIT    = 6;
  localparam int          CAUSE_WDT_BIT     = 5;
  localparam int          CAUSE_EXT_BIT     = 4;
  localparam logic [3:0]  CAUSE_RSVD_VAL    = 4'h0;

  // =====================================================================
  // power control fields
  localparam int          PWR_BROWNOUT_BIT  = 4;
  localparam int          PWR_ADC_BIT       = 2;
  localparam int          PWR_COMP_BIT      = 1;
  localparam logic [7:0]  PWR_RESET_VAL     = 8'h80;

  // =====================================================================
  // mode status fields and option register
  localparam int          MODE_STOP_BIT     = 0;
  localparam int          MODE_HALT_BIT     = 1;
  localparam int          OPT_WDT_RC_EN_BIT = 0;
  localparam int          OPT_WDT_EN_BIT    = 1;
  localparam int          OPT_XTAL_EN_BIT   = 2;
  localparam logic [7:0]  OPT_RESET_VAL     = 8'h03;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b001,
    MODE_HALT   = 3'b010,
    MODE_STOP   = 3'b100
  } power_mode_e;

endpackage

// ==== reset_cause_flags.sv ====
// reset cause flags: event-driven set/clear with clear-on-read
`timescale 1ns/1ps

module reset_cause_flags
  import rst_pwr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       por_event,
  input  wire logic       ext_reset_event,
  input  wire logic       wdt_reset_event,
  input  wire logic       debug_reset_event,
  input  wire logic       wdt_timeout_event,
  input  wire logic       stop_gpio_event,
  input  wire logic       in_stop,
  input  wire logic       clear_read,
  output logic      [3:0] flags
);

  logic [3:0] next_flags;
  logic       smr_gpio;
  logic       smr_wdt;
  logic       wdt_run;

  assign smr_gpio = in_stop && stop_gpio_event;
  // a watchdog expiry in stop recovers the part whether it is set for reset or interrupt
  assign smr_wdt  = in_stop && (wdt_timeout_event || wdt_reset_event);
  assign wdt_run  = !in_stop && (wdt_timeout_event || wdt_reset_event);

  // flags[3]=por, [2]=stop, [1]=wdt, [0]=ext
  always_comb begin
    next_flags = flags;
    if (clear_read) begin
      next_flags = 4'h0;
    end
    // events evaluated after the read clear so a coincident set wins
    if (por_event || debug_reset_event) begin
      next_flags = 4'h8;
    end else if (ext_reset_event) begin
      next_flags = 4'h1;
    end else if (smr_wdt) begin
      next_flags = 4'h6;
    end else if (smr_gpio) begin
      next_flags = 4'h4;
    end else if (wdt_reset_event) begin
      next_flags = 4'h2;
    end else if (wdt_run) begin
      next_flags[3] = 1'b0;
      next_flags[2] = 1'b0;
      next_flags[1] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 4'h8;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// ==== rst_pwr_chk.sv ====
// checker: port-level properties of the reset cause and power control block
`timescale 1ns/1ps
module rst_pwr_chk
  import rst_pwr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        ext_reset_event,
  input wire logic        wdt_reset_event,
  input wire logic        debug_reset_event,
  input wire logic        brownout_reset_event,
  input wire logic        wdt_timeout_event,
  input wire logic        stop_gpio_event,
  input wire logic        irq_pending,
  input wire logic        stop_instr,
  input wire logic        halt_instr,
  input wire logic        watchdog_control_wr,
  input wire logic [7:0]  watchdog_control,
  input wire logic        cpu_clk_en,
  input wire logic        sys_clk_en,
  input wire logic        adc_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire [5:0] ev = {ext_reset_event, wdt_reset_event, debug_reset_event,
                   brownout_reset_event, wdt_timeout_event, stop_gpio_event};
  wire       crd = rd && addr == RESET_CAUSE_ADDR;
  // ==========================================================
  // register side
  // the power-on load lands on the first edge after reset, hence $past(rst_n)
  property p_clear;
    $past(rst_n) && crd && ev == 6'h0 ##1 crd && ev == 6'h0 |=> rdata[7:4] == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("flags survived a read");
  property p_low;
    crd |=> rdata[3:0] == CAUSE_RSVD_VAL;
  endproperty
  a_low: assert property (p_low) else $error("low cause bits not zero");
  property p_wdc;
    wr && addr == RESET_CAUSE_ADDR |=> watchdog_control_wr && watchdog_control == $past(wdata);
  endproperty
  a_wdc: assert property (p_wdc) else $error("watchdog control write lost");
  property p_ext;
    $past(rst_n) && ev == 6'h20 ##1 ev == 6'h0 && !rd ##1 ev == 6'h0 && crd
      |=> rdata[7:4] == 4'h1;
  endproperty
  a_ext: assert property (p_ext) else $error("pin reset pattern wrong");
  property p_gpio;
    !sys_clk_en && ev == 6'h01 ##1 ev == 6'h0 && !rd ##1 ev == 6'h0 && crd
      |=> rdata[7:4] == 4'h4;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin recovery pattern wrong");
  property p_adc;
    wr && addr == POWER_CONTROL_0_ADDR ##1 !wr [*2]
      |-> !sys_clk_en || adc_en == !$past(wdata[PWR_ADC_BIT], 2);
  endproperty
  a_adc: assert property (p_adc) else $error("converter enable wrong");
  // ==========================================================
  // low-power modes
  property p_stop;
    stop_instr && !halt_instr && ev == 6'h0 |=> !cpu_clk_en && !sys_clk_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left clocks on");
  property p_halt;
    halt_instr && !stop_instr && ev == 6'h0 && !irq_pending && sys_clk_en
      |=> !cpu_clk_en && sys_clk_en;
  endproperty
  a_halt: assert property (p_halt) else $error("halt clock enables wrong");
  property p_wake;
    !cpu_clk_en && sys_clk_en && irq_pending && !halt_instr |=> cpu_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not end halt");
  c_stop: cover property (stop_instr ##1 !sys_clk_en);
  c_wake: cover property (!cpu_clk_en && irq_pending ##1 cpu_clk_en);
  c_dbl: cover property (crd ##1 crd);
endmodule

bind reset_status_power_ctrl rst_pwr_chk chk_u (
  .clk                  (clk),
  .rst_n                (rst_n),
  .addr                 (addr),
  .wdata                (wdata),
  .wr                   (wr),
  .rd                   (rd),
  .rdata                (rdata),
  .ext_reset_event      (ext_reset_event),
  .wdt_reset_event      (wdt_reset_event),
  .debug_reset_event    (debug_reset_event),
  .brownout_reset_event (brownout_reset_event),
  .wdt_timeout_event    (wdt_timeout_event),
  .stop_gpio_event      (stop_gpio_event),
  .irq_pending          (irq_pending),
  .stop_instr           (stop_instr),
  .halt_instr           (halt_instr),
  .watchdog_control_wr  (watchdog_control_wr),
  .watchdog_control     (watchdog_control),
  .cpu_clk_en           (cpu_clk_en),
  .sys_clk_en           (sys_clk_en),
  .adc_en               (adc_en)
);

// ==== tb_reset_status_power_ctrl.sv ====
// testbench: self-checking run of the reset cause and power control block
`timescale 1ns/1ps
module tb_reset_status_power_ctrl;
  import rst_pwr_pkg::*;
  logic        clk = 0, rst_n = 0, por_n = 0, wr = 0, rd = 0;
  logic        irq_pending = 0, brownout_stop_option = 1;
  logic [11:0] addr = 0;
  logic [7:0]  wdata = 0, ev = 0, v, rdata, watchdog_control, mp = 8'h80;
  logic        watchdog_control_wr, cpu_clk_en, sys_clk_en, osc_en, xtal_pins_en;
  logic        wdt_rc_run, wdt_logic_run, periph_clk_en, brownout_en, adc_en, comp_en;
  wire         ext_reset_event = ev[0], wdt_reset_event = ev[1], debug_reset_event = ev[2];
  wire         brownout_reset_event = ev[3], wdt_timeout_event = ev[4];
  wire         stop_gpio_event = ev[5], stop_instr = ev[6], halt_instr = ev[7];
  wire [7:0]   mv = {cpu_clk_en, sys_clk_en, osc_en, periph_clk_en, xtal_pins_en,
                     wdt_rc_run, wdt_logic_run, brownout_en};
  int          fails = 0, checks_done = 0, mf = 8, cyc = 0;
  int          src[5] = '{8, 4, 1, 3, 0};
  reset_status_power_ctrl dut_u (
    .clk                  (clk),
    .rst_n                (rst_n),
    .por_n                (por_n),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .ext_reset_event      (ext_reset_event),
    .wdt_reset_event      (wdt_reset_event),
    .debug_reset_event    (debug_reset_event),
    .brownout_reset_event (brownout_reset_event),
    .wdt_timeout_event    (wdt_timeout_event),
    .stop_gpio_event      (stop_gpio_event),
    .irq_pending          (irq_pending),
    .stop_instr           (stop_instr),
    .halt_instr           (halt_instr),
    .brownout_stop_option (brownout_stop_option),
    .watchdog_control_wr  (watchdog_control_wr),
    .watchdog_control     (watchdog_control),
    .cpu_clk_en           (cpu_clk_en),
    .sys_clk_en           (sys_clk_en),
    .osc_en               (osc_en),
    .xtal_pins_en         (xtal_pins_en),
    .wdt_rc_run           (wdt_rc_run),
    .wdt_logic_run        (wdt_logic_run),
    .periph_clk_en        (periph_clk_en),
    .brownout_en          (brownout_en),
    .adc_en               (adc_en),
    .comp_en              (comp_en)
  );
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      stop_test();
    end
  end
  // ==========================================================
  // bus, event and check tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic do_reset(bit p);
    @(posedge clk);
    rst_n <= 1'b0;
    if (p) por_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    if (p) mp = PWR_RESET_VAL;
    mf = 8;
    @(posedge clk);
  endtask
  task automatic wr_reg(logic [11:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [11:0] a, int n, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    repeat (n) @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic rd_cause();
    rd_reg(RESET_CAUSE_ADDR, 1, v);
    chk("cause", 8'(mf << 4), v);
    mf = 0;
  endtask
  // index 8 is the interrupt level, held for one cycle only
  task automatic fire(int k);
    @(posedge clk);
    if (k == 8) irq_pending <= 1'b1;
    else ev <= 8'(1 << k);
    @(posedge clk);
    irq_pending <= 1'b0;
    ev <= 8'h0;
    #1;
  endtask
  // codes 4..6 enter stop first, so recovery always starts from stop
  task automatic cause(int c);
    if (c >= 4) fire(6);
    fire(c == 3 || c == 5 ? 4 : c == 4 ? 5 : c == 6 ? 1 : c);
    case (c)
      0: mf = 1;
      1: mf = 2;
      2: mf = 8;
      3: mf = (mf & 1) | 2;
      4: mf = 4;
      default: mf = 6;
    endcase
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h40e80404));
    do_reset(1'b1);
    rd_cause();
    cause(2);
    rd_reg(RESET_CAUSE_ADDR, 2, v);
    chk("cause twice", 8'h00, v);
    mf = 0;
    for (int c = 0; c < 7; c++) begin
      cause(c);
      // software reads the cause before it would clear a watchdog interrupt
      rd_cause();
    end
    @(posedge clk);
    addr <= RESET_CAUSE_ADDR;
    rd <= 1'b1;
    ev <= 8'h01;
    @(posedge clk);
    rd <= 1'b0;
    ev <= 8'h0;
    mf = 1;
    rd_cause();
    for (int i = 0; i < 40; i++) begin
      cause($urandom_range(6));
      if ($urandom_range(2) == 0) rd_cause();
    end
    for (int i = 0; i < 6; i++) begin
      mp = 8'h80 | 8'($urandom & 32'h16);
      wr_reg(POWER_CONTROL_0_ADDR, mp);
      repeat (2) @(posedge clk);
      v = {5'h0, ~mp[4], ~mp[2], ~mp[1]};
      #1 chk("enables", v, {5'h0, brownout_en, adc_en, comp_en});
      rd_reg(POWER_CONTROL_0_ADDR, 1, v);
      chk("power", mp, v);
    end
    wr_reg(RESET_CAUSE_ADDR, 8'h5a);
    #1 chk("wd strobe", 8'h01, {7'h0, watchdog_control_wr});
    chk("wd data", 8'h5a, watchdog_control);
    rd_cause();
    wr_reg(12'h123, 8'hff);
    rd_reg(12'h123, 1, v);
    chk("unmapped", 8'h00, v);
    do_reset(1'b0);
    rd_reg(POWER_CONTROL_0_ADDR, 1, v);
    chk("power kept", mp, v);
    do_reset(1'b1);
    rd_reg(POWER_CONTROL_0_ADDR, 1, v);
    chk("power reset", PWR_RESET_VAL, v);
    @(posedge clk);
    brownout_stop_option <= 1'b0;
    fire(6);
    @(posedge clk);
    #1 chk("stop", 8'h06, mv);
    rd_reg(MODE_STATUS_ADDR, 1, v);
    chk("mode stop", 8'h01, v);
    fire(5);
    wr_reg(OPTION_CTRL_ADDR, 8'h04);
    brownout_stop_option <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("xtal", 8'hf8, mv & 8'hf8);
    rd_reg(OPTION_CTRL_ADDR, 1, v);
    chk("option", 8'h04, v);
    fire(6);
    @(posedge clk);
    #1 chk("stop quiet", 8'h01, mv);
    fire(5);
    fire(7);
    @(posedge clk);
    #1 chk("halt", 8'h7d, mv & 8'hfd);
    rd_reg(MODE_STATUS_ADDR, 1, v);
    chk("mode halt", 8'h02, v);
    foreach (src[i]) begin
      if (i > 0) begin
        fire(7);
        chk("halted", 8'h00, {7'h0, cpu_clk_en});
      end
      fire(src[i]);
      chk("wake", 8'h01, {7'h0, cpu_clk_en});
    end
    stop_test();
  end
endmodule
